// *** adsl_map.svh ***
// Register map, field positions and reset values of the scan controller
// Contract
// RULE1: enabled channels convert in ascending order
// RULE2: start refused while no channel enabled
// RULE3: channels 16 and 17 have enable bits
// RULE4: continuous mode waits interval clocks between scans
// RULE5: interval runs from scan end to next start
// RULE6: slowest conversion clock forces zero interval
// RULE7: limit flags update only while detection enabled
// RULE8: two-bit field selects the limit condition
// RULE9: match sets channel flag and raises interrupt
// RULE10: one limit pair applies to every channel
// RULE11: upper limit bits 15-6, reset all ones
// RULE12: lower limit bits 15-6, reset zero
// RULE13: reference enable powers reference and sensor
// RULE14: reference source select, code 11 means supply
// RULE15: software waits reference settling before converting
// RULE16: software prepares reference before temperature channel
// RULE17: timing bit 0 interrupts once per scan
// RULE18: timing bit 1 interrupts per channel
// RULE19: limit detection overrides interrupt timing
// RULE20: match flag clears only by writing one
// RULE21: continuous bit selects repeated or single scan
// RULE22: limits and result compare unsigned, bits 15-6
`ifndef ADSL_MAP_SVH
`define ADSL_MAP_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define ADSL_IDX_INTERVAL 16'hF832
`define ADSL_IDX_LMODE    16'hF834
`define ADSL_IDX_UPPER    16'hF836
`define ADSL_IDX_LOWER    16'hF838
`define ADSL_IDX_IMODE    16'hF83C
`define ADSL_IDX_CHEN     16'hF840
`define ADSL_IDX_CTRL     16'hF841
`define ADSL_IDX_STATUS   16'hF842
`define ADSL_IDX_REFCTL   16'hF843

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADSL_LM_EN      0
`define ADSL_LM_COND_LO 8
`define ADSL_LIM_LSB    6
`define ADSL_CT_RUN     0
`define ADSL_CT_CONT    1
`define ADSL_CT_CLK_LO  2
`define ADSL_REF_EN     0
`define ADSL_REF_SRC_LO 4

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ADSL_UPPER_RST  16'hFFC0
`define ADSL_LOWER_RST  16'h0000
`define ADSL_CLK_SLOW   3'h7
`define ADSL_REF_SUPPLY 2'h0
`define ADSL_REF_BAD    2'h3

`endif

// *** adsl_pkg.sv ***
// Types shared by the scan controller and its limit comparator
package adsl_pkg;

	// Sequencer states, Gray coded along idle-start-busy-gap
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_BUSY  = 2'h3,
		ST_GAP   = 2'h2
	} adsl_state_t;

	// Limit condition codes
	typedef enum logic [1:0] {
		LC_INSIDE = 2'h0,
		LC_ABOVE  = 2'h1,
		LC_BELOW  = 2'h2,
		LC_OUTSIDE = 2'h3
	} adsl_cond_t;

	// Limit check carrier
	typedef struct packed {
		logic [9:0] upper;
		logic [9:0] lower;
		adsl_cond_t cond;
	} adsl_limit_t;

endpackage : adsl_pkg

// *** adsl_limit_cmp.sv ***
// Unsigned window comparator for one conversion result
`timescale 1ns/1ns
module adsl_limit_cmp (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire logic [15:0]        i_result,
	input  wire adsl_pkg::adsl_limit_t i_lim,
	output logic                    o_match
);
	logic [9:0] res;
	logic       above;
	logic       below;

	// Compare the aligned ten-bit value
	assign res   = i_result[15:6];        // RULE22
	assign above = res > i_lim.upper;
	assign below = res < i_lim.lower;

	// Pick the selected condition
	always_comb begin
		case (i_lim.cond)                 // RULE8
			adsl_pkg::LC_INSIDE:  o_match = !above && !below;
			adsl_pkg::LC_ABOVE:   o_match = above;
			adsl_pkg::LC_BELOW:   o_match = below;
			adsl_pkg::LC_OUTSIDE: o_match = above || below;
			default:              o_match = 1'b0;
		endcase
	end

	above_cond_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_lim.cond == adsl_pkg::LC_ABOVE) |-> (o_match == above)) // RULE8
		else $error("above condition wrong");
endmodule : adsl_limit_cmp

// *** adsl_scan_ctrl.sv ***
// Scan sequencer, limit detection and register file of the converter
`timescale 1ns/1ns
`include "adsl_map.svh"
module adsl_scan_ctrl (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [17:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_conv_done,
	input  wire logic [15:0] i_conv_result,
	output logic             o_conv_start,
	output logic      [4:0]  o_conv_channel,
	output logic             o_irq,
	output logic             o_ref_enable,
	output logic             o_temp_sensor_enable,
	output logic      [1:0]  o_ref_select
);
	localparam int NCH = 18;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge32(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge32

	// Lowest enabled channel at or above a start index
	function automatic logic [5:0] find_ch(
		input logic [NCH-1:0] en,
		input logic [5:0]     from
	);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && (6'(i) >= from)) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction : find_ch

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic                   wait_q;
	logic [31:0]            rdata_q;
	logic [31:0]            rd_d;
	logic [15:0]            interval_q;
	logic                   lim_en_q;
	adsl_pkg::adsl_cond_t   cond_q;
	logic [9:0]             upper_q;
	logic [9:0]             lower_q;
	logic                   imode_q;
	logic [NCH-1:0]         chen_q;
	logic                   cont_q;
	logic [2:0]             clksel_q;
	logic                   run_q;
	logic [NCH-1:0]         flags_q;
	logic                   ref_en_q;
	logic [1:0]             ref_src_q;
	adsl_pkg::adsl_state_t  st_q;
	logic [4:0]             ch_q;
	logic [15:0]            cnt_q;
	logic                   start_q;
	logic                   irq_q;
	logic                   match;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic        req;
	logic        wr;
	logic [15:0] idx;
	logic [31:0] wdat;
	logic        ctrl_wr;
	logic        sts_wr;

	assign req  = i_avs_read || i_avs_write;
	assign wr   = i_avs_write && !wait_q;
	assign idx  = i_avs_address[17:2];
	assign ctrl_wr = wr && (idx == `ADSL_IDX_CTRL) && i_avs_byteenable[0];
	assign sts_wr  = wr && (idx == `ADSL_IDX_STATUS);
	assign wdat = i_avs_writedata;

	// One wait cycle per access, request taken on the next edge
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(req && wait_q);
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_avs_read && wait_q) begin
			rdata_q <= rd_d;
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata    = rdata_q;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [31:0] m_int;
	logic [31:0] m_lm;
	logic [31:0] m_up;
	logic [31:0] m_lo;
	logic [31:0] m_ch;
	logic [31:0] m_ct;
	localparam logic [15:0] UPR = `ADSL_UPPER_RST;
	localparam logic [15:0] LWR = `ADSL_LOWER_RST;

	assign m_int = merge32({16'h0000, interval_q}, wdat, i_avs_byteenable);
	assign m_lm  = merge32(32'h0000_0000, wdat, i_avs_byteenable);
	assign m_up  = merge32({16'h0000, upper_q, 6'h00}, wdat,
		i_avs_byteenable);
	assign m_lo  = merge32({16'h0000, lower_q, 6'h00}, wdat,
		i_avs_byteenable);
	assign m_ch  = merge32({14'h0000, chen_q}, wdat, i_avs_byteenable);
	assign m_ct  = merge32({27'h0, clksel_q, cont_q, 1'b0}, wdat,
		i_avs_byteenable);

	// Register writes, low six limit bits are not stored
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			interval_q <= 16'h0000;
			lim_en_q   <= 1'b0;
			cond_q     <= adsl_pkg::LC_INSIDE;
			upper_q    <= UPR[15:6];          // RULE11
			lower_q    <= LWR[15:6];          // RULE12
			imode_q    <= 1'b0;
			chen_q     <= {NCH{1'b0}};        // RULE3
			cont_q     <= 1'b0;
			clksel_q   <= 3'h0;
			ref_en_q   <= 1'b0;
			ref_src_q  <= `ADSL_REF_SUPPLY;
		end else if (wr) begin
			case (idx)
				`ADSL_IDX_INTERVAL: interval_q <= m_int[15:0];
				`ADSL_IDX_LMODE: begin
					if (i_avs_byteenable[0]) begin
						lim_en_q <= m_lm[`ADSL_LM_EN];
					end
					if (i_avs_byteenable[1]) begin
						cond_q <= adsl_pkg::adsl_cond_t'(
							m_lm[`ADSL_LM_COND_LO +: 2]);
					end
				end
				`ADSL_IDX_UPPER: upper_q <= m_up[15:6];  // RULE11
				`ADSL_IDX_LOWER: lower_q <= m_lo[15:6];  // RULE12
				`ADSL_IDX_IMODE: begin
					if (i_avs_byteenable[0]) begin
						imode_q <= wdat[0];
					end
				end
				`ADSL_IDX_CHEN: chen_q <= m_ch[NCH-1:0]; // RULE3
				`ADSL_IDX_CTRL: begin
					cont_q   <= m_ct[`ADSL_CT_CONT];     // RULE21
					clksel_q <= m_ct[`ADSL_CT_CLK_LO +: 3];
				end
				`ADSL_IDX_REFCTL: begin
					if (i_avs_byteenable[0]) begin
						ref_en_q  <= m_lm[`ADSL_REF_EN]; // RULE13
						ref_src_q <= m_lm[`ADSL_REF_SRC_LO +: 2];
					end
				end
				default: ;
			endcase
		end
	end

	// Reference drive, the unused code falls back to the supply pin
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_ref_enable         <= 1'b0;
			o_temp_sensor_enable <= 1'b0;
			o_ref_select         <= `ADSL_REF_SUPPLY;
		end else begin
			o_ref_enable         <= ref_en_q;    // RULE13
			o_temp_sensor_enable <= ref_en_q;    // RULE13
			o_ref_select <= (ref_src_q == `ADSL_REF_BAD) ?
				`ADSL_REF_SUPPLY : ref_src_q;    // RULE14
		end
	end

	// ----------------------------------------------------------------
	// Scan sequencer
	// ----------------------------------------------------------------
	logic [5:0] first;
	logic [5:0] nxt;
	logic       done;
	logic       last;
	logic       gap_zero;

	assign first    = find_ch(chen_q, 6'h00);
	assign nxt      = find_ch(chen_q, {1'b0, ch_q} + 6'h01);   // RULE1
	assign done     = (st_q == adsl_pkg::ST_BUSY) && i_conv_done;
	assign last     = done && !nxt[5];
	assign gap_zero = (clksel_q == `ADSL_CLK_SLOW) ||
		(interval_q == 16'h0000);                               // RULE6

	// State, channel, interval count and run bit
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_q    <= adsl_pkg::ST_IDLE;
			run_q   <= 1'b0;
			ch_q    <= 5'h00;
			cnt_q   <= 16'h0000;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (ctrl_wr && !wdat[`ADSL_CT_RUN]) begin
				run_q <= 1'b0;
				st_q  <= adsl_pkg::ST_IDLE;
			end else begin
				case (st_q)
					adsl_pkg::ST_IDLE: begin
						if (ctrl_wr && first[5]) begin       // RULE2
							run_q <= 1'b1;
							ch_q  <= first[4:0];              // RULE1
							st_q  <= adsl_pkg::ST_START;
						end
					end
					adsl_pkg::ST_START: begin
						start_q <= 1'b1;
						st_q    <= adsl_pkg::ST_BUSY;
					end
					adsl_pkg::ST_BUSY: begin
						if (done && nxt[5]) begin
							ch_q <= nxt[4:0];                 // RULE1
							st_q <= adsl_pkg::ST_START;
						end else if (done && cont_q && first[5]) begin
							ch_q <= first[4:0];               // RULE21
							if (gap_zero) begin
								st_q <= adsl_pkg::ST_START;   // RULE6
							end else begin
								cnt_q <= interval_q;          // RULE5
								st_q  <= adsl_pkg::ST_GAP;
							end
						end else if (done) begin
							run_q <= 1'b0;                    // RULE21
							st_q  <= adsl_pkg::ST_IDLE;
						end
					end
					adsl_pkg::ST_GAP: begin
						if (cnt_q <= 16'h0001) begin
							st_q <= adsl_pkg::ST_START;       // RULE4
						end else begin
							cnt_q <= cnt_q - 16'h0001;        // RULE4
						end
					end
					default: st_q <= adsl_pkg::ST_IDLE;
				endcase
			end
		end
	end

	assign o_conv_start   = start_q;
	assign o_conv_channel = ch_q;

	// ----------------------------------------------------------------
	// Limit detection and interrupt
	// ----------------------------------------------------------------
	adsl_pkg::adsl_limit_t lim;
	logic                  hit;
	logic [NCH-1:0]        set_v;
	logic [NCH-1:0]        clr_v;

	assign lim = '{upper: upper_q, lower: lower_q, cond: cond_q};

	// Shared limit pair for every channel
	adsl_limit_cmp u_cmp (                   // RULE10
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_result (i_conv_result),
		.i_lim    (lim),
		.o_match  (match)
	);

	assign hit   = done && lim_en_q && match;                  // RULE7
	assign set_v = hit ? (NCH'(1) << ch_q) : {NCH{1'b0}};
	assign clr_v = sts_wr ? m_lm[NCH-1:0] : {NCH{1'b0}};

	// Sticky match flags, a new match beats a clear
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			flags_q <= {NCH{1'b0}};
		end else begin
			flags_q <= (flags_q & ~clr_v) | set_v;  // RULE9 RULE20
		end
	end

	// Interrupt pulse source selection
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			irq_q <= 1'b0;
		end else if (lim_en_q) begin
			irq_q <= hit;                          // RULE9 RULE19
		end else if (imode_q) begin
			irq_q <= done;                         // RULE18
		end else begin
			irq_q <= last;                         // RULE17
		end
	end

	assign o_irq = irq_q;

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = 32'h0000_0000;
		case (idx)
			`ADSL_IDX_INTERVAL: rd_d[15:0] = interval_q;
			`ADSL_IDX_LMODE: begin
				rd_d[`ADSL_LM_EN] = lim_en_q;
				rd_d[`ADSL_LM_COND_LO +: 2] = cond_q;
			end
			`ADSL_IDX_UPPER: rd_d[15:6] = upper_q;
			`ADSL_IDX_LOWER: rd_d[15:6] = lower_q;
			`ADSL_IDX_IMODE: rd_d[0] = imode_q;
			`ADSL_IDX_CHEN:  rd_d[NCH-1:0] = chen_q;
			`ADSL_IDX_CTRL: begin
				rd_d[`ADSL_CT_RUN]  = run_q;
				rd_d[`ADSL_CT_CONT] = cont_q;
				rd_d[`ADSL_CT_CLK_LO +: 3] = clksel_q;
			end
			`ADSL_IDX_STATUS: rd_d[NCH-1:0] = flags_q;
			`ADSL_IDX_REFCTL: begin
				rd_d[`ADSL_REF_EN] = ref_en_q;
				rd_d[`ADSL_REF_SRC_LO +: 2] = ref_src_q;
			end
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// Next channel of a scan, no stop written while it is set up
	sequence scan_step_s;
		done && nxt[5] && !ctrl_wr ##1 !ctrl_wr;
	endsequence

	// Last interval count, no stop written while restarting
	sequence gap_end_s;
		(st_q == adsl_pkg::ST_GAP) && (cnt_q == 16'h0001) && !ctrl_wr
		##1 !ctrl_wr;
	endsequence

	scan_order_a: assert property (scan_step_s |->          // RULE1
		(ch_q > $past(ch_q)) ##1 o_conv_start)
		else $error("channel order not ascending");
	no_start_a: assert property ((st_q == adsl_pkg::ST_IDLE &&  // RULE2
		ctrl_wr && chen_q == {NCH{1'b0}}) |=> !run_q)
		else $error("run set with no channel");
	gap_load_a: assert property ((last && cont_q && first[5] &&  // RULE5
		!gap_zero && !ctrl_wr) |=>
		(st_q == adsl_pkg::ST_GAP && cnt_q == $past(interval_q)))
		else $error("interval count not loaded");
	gap_end_a: assert property (gap_end_s |=> o_conv_start)    // RULE4
		else $error("scan did not restart after interval");
	slow_clk_a: assert property ((last && cont_q && first[5] &&  // RULE6
		clksel_q == `ADSL_CLK_SLOW && !ctrl_wr) |=>
		st_q == adsl_pkg::ST_START)
		else $error("slow clock interval not zero");
	flag_hold_a: assert property ((!lim_en_q && !sts_wr) |=>     // RULE7
		flags_q == $past(flags_q))
		else $error("flags changed while disabled");
	match_set_a: assert property (hit |=>                       // RULE9
		(flags_q[$past(ch_q)] && o_irq))
		else $error("match not flagged");
	irq_scan_a: assert property ((!lim_en_q && !imode_q && done) // RULE17
		|=> (o_irq == !$past(nxt[5])))
		else $error("scan interrupt wrong");
	irq_each_a: assert property ((!lim_en_q && imode_q && done)  // RULE18
		|=> o_irq)
		else $error("channel interrupt missing");
	flag_keep_a: assert property ((flags_q != {NCH{1'b0}} &&     // RULE20
		!sts_wr) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
		else $error("flag lost without clear");
	ref_sel_a: assert property (o_ref_select != `ADSL_REF_BAD)  // RULE14
		else $error("unused reference code driven");
endmodule : adsl_scan_ctrl

// *** adsl_core_model.sv ***
// Behavioural converter core that answers start pulses with results
`timescale 1ns/1ns
module adsl_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_start,
	input  wire logic [4:0]  i_channel,
	input  wire logic [3:0]  i_lat,
	input  wire logic [9:0]  i_base,
	output logic             o_done,
	output logic      [15:0] o_result
);
	logic       busy_q;
	logic [3:0] cnt_q;
	logic [9:0] val;

	// Each channel converts to base plus 37 per channel number
	assign val = i_base + {5'h00, i_channel} * 10'h025;

	// Scramble the result lines while holding off for the latency, pulse done with the result, then scramble again
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_srst) begin
			busy_q   <= 1'b0;
			cnt_q    <= 4'h0;
			o_result <= 16'h0000;
		end else if (i_start) begin
			busy_q   <= 1'b1;
			cnt_q    <= i_lat;
			o_result <= ~o_result;
		end else if (busy_q && cnt_q == 4'h0) begin
			busy_q   <= 1'b0;
			o_done   <= 1'b1;
			o_result <= {val, 6'h00};
		end else begin
			cnt_q    <= cnt_q - 4'h1;
			o_result <= ~o_result;
		end
	end
endmodule : adsl_core_model

// *** tb_adsl_scan_ctrl.sv ***
// Self-checking bench of the scan controller with a core model
`timescale 1ns/1ns
`include "adsl_map.svh"
module tb_adsl_scan_ctrl;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [17:0] addr = 18'h00000;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        wait_r;
	logic        done;
	logic [15:0] result;
	logic        conv_start;
	logic [4:0]  conv_chan;
	logic        irq;
	logic        ref_en;
	logic        temp_en;
	logic [1:0]  ref_sel;
	logic [3:0]  lat = 4'h0;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n_start = 0;
	int          n_irq = 0;
	int          last_done = 0;
	int          gap = 0;
	logic [4:0]  order_q[$];

	// Clock of 50 ns period
	always #25 clk = ~clk;

	adsl_scan_ctrl i_adsl_scan_ctrl (.i_clk(clk), .i_srst(srst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
		.i_conv_done(done), .i_conv_result(result),
		.o_conv_start(conv_start), .o_conv_channel(conv_chan),
		.o_irq(irq), .o_ref_enable(ref_en),
		.o_temp_sensor_enable(temp_en), .o_ref_select(ref_sel));

	adsl_core_model i_adsl_core_model (.i_clk(clk), .i_srst(srst),
		.i_start(conv_start), .i_channel(conv_chan), .i_lat(lat),
		.i_base(10'h064), .o_done(done), .o_result(result));

	// Watch starts, gaps and interrupts; cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1) last_done <= cyc;
		if (conv_start === 1'b1) begin
			n_start <= n_start + 1;
			gap <= cyc - last_done;
			order_q.push_back(conv_chan);
		end
		if (irq === 1'b1) n_irq <= n_irq + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [15:0] idx,
		input logic [31:0] wd, output logic [31:0] rv);
		@(posedge clk);
		addr <= {idx, 2'b00};
		wdata <= wd;
		wr <= w;
		rd <= ~w;
		do @(posedge clk); while (wait_r !== 1'b0);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [15:0] idx, input logic [31:0] v);
		logic [31:0] d;
		bus(1'b1, idx, v, d);
	endtask : wreg

	task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, idx, 32'h0, v);
		chk(v, e);
	endtask : rchk

	task automatic wait_idle();
		logic [31:0] v;
		v = 32'h1;
		for (int k = 0; k < 300 && v[0] !== 1'b0; k++)
			bus(1'b0, `ADSL_IDX_CTRL, 32'h0, v);
		chk(v[0], 1'b0);
		repeat (3) @(posedge clk);
	endtask : wait_idle

	task automatic wait_starts(input int n);
		int s0;
		s0 = n_start;
		for (int k = 0; k < 600 && n_start < s0 + n; k++) @(posedge clk);
		chk(n_start >= s0 + n, 1);
	endtask : wait_starts

	// Reset values, read-only limit bits and an unmapped place
	task automatic t_regs();
		rchk(`ADSL_IDX_INTERVAL, 32'h0);
		rchk(`ADSL_IDX_LMODE, 32'h0);
		rchk(`ADSL_IDX_UPPER, 32'hFFC0);
		rchk(`ADSL_IDX_LOWER, 32'h0);
		rchk(`ADSL_IDX_IMODE, 32'h0);
		rchk(`ADSL_IDX_CHEN, 32'h0);
		rchk(`ADSL_IDX_REFCTL, 32'h0);
		wreg(16'hF800, 32'hFFFF);
		rchk(16'hF800, 32'h0);
		wreg(`ADSL_IDX_UPPER, 32'hFFFF);
		rchk(`ADSL_IDX_UPPER, 32'hFFC0);
		wreg(`ADSL_IDX_LOWER, 32'h1234);
		rchk(`ADSL_IDX_LOWER, 32'h1200);
		wreg(`ADSL_IDX_INTERVAL, 32'hABCD);
		rchk(`ADSL_IDX_INTERVAL, 32'hABCD);
	endtask : t_regs

	// Start with no channel enabled is refused
	task automatic t_no_chan();
		int s0;
		s0 = n_start;
		wreg(`ADSL_IDX_CTRL, 32'h1);
		rchk(`ADSL_IDX_CTRL, 32'h0);
		repeat (10) @(posedge clk);
		chk(n_start - s0, 0);
	endtask : t_no_chan

	// Single scan over sparse channels including 16 and 17
	task automatic t_order();
		logic [4:0] e[4];
		int i0;
		e = '{5'h01, 5'h03, 5'h10, 5'h11};
		wreg(`ADSL_IDX_REFCTL, 32'h21);
		repeat (4000) @(posedge clk);
		wreg(`ADSL_IDX_CHEN, 32'h3000A);
		order_q.delete();
		i0 = n_irq;
		wreg(`ADSL_IDX_CTRL, 32'h1);
		wait_idle();
		chk(order_q.size(), 4);
		for (int i = 0; i < 4; i++) chk(order_q[i], e[i]);
		chk(n_irq - i0, 1);
		rchk(`ADSL_IDX_CTRL, 32'h0);
	endtask : t_order

	// Interrupt after every channel with a slow core
	task automatic t_each();
		int i0;
		lat <= 4'h5;
		wreg(`ADSL_IDX_IMODE, 32'h1);
		wreg(`ADSL_IDX_CHEN, 32'h5);
		i0 = n_irq;
		wreg(`ADSL_IDX_CTRL, 32'h1);
		wait_idle();
		chk(n_irq - i0, 2);
	endtask : t_each

	// Results 100,137,174,211 against lower 137 and upper 174
	task automatic t_limit();
		logic [31:0] e[4];
		int i0;
		e = '{32'h6, 32'h8, 32'h1, 32'h9};
		wreg(`ADSL_IDX_UPPER, 32'h2B80);
		wreg(`ADSL_IDX_LOWER, 32'h2240);
		wreg(`ADSL_IDX_CHEN, 32'hF);
		wreg(`ADSL_IDX_CTRL, 32'h1);
		wait_idle();
		rchk(`ADSL_IDX_STATUS, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wreg(`ADSL_IDX_LMODE, (c << 8) | 1);
			i0 = n_irq;
			wreg(`ADSL_IDX_CTRL, 32'h1);
			wait_idle();
			rchk(`ADSL_IDX_STATUS, e[c]);
			chk(n_irq - i0, $countones(e[c]));
			wreg(`ADSL_IDX_STATUS, 32'h0);
			rchk(`ADSL_IDX_STATUS, e[c]);
			wreg(`ADSL_IDX_STATUS, 32'hF);
			rchk(`ADSL_IDX_STATUS, 32'h0);
		end
		wreg(`ADSL_IDX_LMODE, 32'h0);
	endtask : t_limit

	// Continuous scans of channels 2 and 5, gap from last done to start
	task automatic t_interval();
		lat <= 4'h0;
		wreg(`ADSL_IDX_IMODE, 32'h0);
		wreg(`ADSL_IDX_CHEN, 32'h24);
		wreg(`ADSL_IDX_INTERVAL, 32'h14);
		wreg(`ADSL_IDX_CTRL, 32'h3);
		wait_starts(3);
		chk(gap, 22);
		wreg(`ADSL_IDX_CTRL, 32'h0);
		wreg(`ADSL_IDX_CTRL, 32'h1F);
		wait_starts(3);
		chk(gap, 2);
		wreg(`ADSL_IDX_CTRL, 32'h0);
	endtask : t_interval

	// Every reference source code with enable toggled
	task automatic t_ref();
		for (int s = 0; s < 4; s++) begin
			wreg(`ADSL_IDX_REFCTL, (s << 4) | (s & 1));
			repeat (2) @(posedge clk);
			chk(ref_sel, (s == 3) ? 0 : s);
			chk(ref_en, s & 1);
			chk(temp_en, s & 1);
		end
	endtask : t_ref

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_no_chan();
		t_order();
		t_each();
		t_limit();
		t_interval();
		t_ref();
		give_verdict();
	end
endmodule : tb_adsl_scan_ctrl
